// File: hw/bytewise_io_port.sv
// Bytewise general-purpose I/O port with data-space register access
`timescale 1ns/100ps
`default_nettype none

module bytewise_io_port #(
    parameter logic [7:0] LEVEL_ADDR = io_port_pkg::ADDR_LEVEL,
    parameter logic [7:0] DIR_ADDR = io_port_pkg::ADDR_DIR,
    parameter logic [7:0] OPT_ADDR = io_port_pkg::ADDR_OPT,
    parameter io_port_pkg::byte_t ANALOG_CAPABLE = io_port_pkg::ANALOG_CAPABLE_ALL
) (
    input wire logic clock,
    input wire logic sys_rst,
    // Data-space access from the core
    input wire logic [7:0] dataAddr,
    input wire logic dataWrEn,
    input wire logic dataRdEn,
    input wire io_port_pkg::byte_t dataWrData,
    output io_port_pkg::byte_t dataRdData,
    output logic dataRdValid,
    output logic dataHit,
    // Pads
    input wire io_port_pkg::byte_t padIn,
    output io_port_pkg::byte_t padOut,
    output io_port_pkg::byte_t padOe,
    output io_port_pkg::byte_t pullUpEn,
    // Interrupt unit
    output io_port_pkg::byte_t irqLineEn,
    output io_port_pkg::byte_t irqLineLevel,
    // Analog converter selector
    output io_port_pkg::byte_t analogSel,
    output io_port_pkg::line_idx_t analogIndex,
    output logic analogValid,
    output logic analogConflict,
    // Line status
    output io_port_pkg::byte_t lineIsOutput
);

    // ==========================================================
    // Local state
    typedef struct packed {
        io_port_pkg::byte_t pinSample;
        io_port_pkg::byte_t rdData;
        logic rdValid;
        io_port_pkg::line_idx_t analogIndex;
        logic analogValid;
        logic analogConflict;
    } state_s;

    state_s state_q;
    state_s state_d;

    io_port_pkg::byte_t levelLatch;
    io_port_pkg::byte_t dirReg;
    io_port_pkg::byte_t optReg;
    io_port_pkg::byte_t levelRead;
    io_port_pkg::byte_t lineAnalog;
    io_port_pkg::byte_t lineIrqEn;
    io_port_pkg::byte_t lineIrqLevel;
    io_port_pkg::byte_t linePadOut;
    io_port_pkg::byte_t linePadOe;
    io_port_pkg::byte_t linePullUp;

    logic hitLevel;
    logic hitDir;
    logic hitOpt;
    logic wrLevel;
    logic wrDir;
    logic wrOpt;

    // ==========================================================
    // Address decode
    always_comb begin
        hitLevel = 1'b0;
        hitDir = 1'b0;
        hitOpt = 1'b0;
        if (dataAddr == LEVEL_ADDR) begin
            hitLevel = 1'b1;
        end else if (dataAddr == DIR_ADDR) begin
            hitDir = 1'b1;
        end else if (dataAddr == OPT_ADDR) begin
            hitOpt = 1'b1;
        end
    end

    // Write strobes per register
    assign wrLevel = dataWrEn & hitLevel;
    assign wrDir = dataWrEn & hitDir;
    assign wrOpt = dataWrEn & hitOpt;
    assign dataHit = hitLevel | hitDir | hitOpt;

    // ==========================================================
    // Port registers, all cleared on reset
    io_reg_byte u_level_reg (
        .clock(clock),
        .sys_rst(sys_rst),
        .wrEn(wrLevel),
        .wrData(dataWrData),
        .value(levelLatch)
    );

    io_reg_byte u_dir_reg (
        .clock(clock),
        .sys_rst(sys_rst),
        .wrEn(wrDir),
        .wrData(dataWrData),
        .value(dirReg)
    );

    io_reg_byte u_opt_reg (
        .clock(clock),
        .sys_rst(sys_rst),
        .wrEn(wrOpt),
        .wrData(dataWrData),
        .value(optReg)
    );

    // ==========================================================
    // Per-line mode decode
    for (genvar n = 0; n < io_port_pkg::LINES; n++) begin : g_line
        port_line u_line (
            .dirBit(dirReg[n]),
            .optBit(optReg[n]),
            .latchBit(levelLatch[n]),
            .pinLevel(state_q.pinSample[n]),
            .analogOk(ANALOG_CAPABLE[n]),
            .mode(),
            .padOut(linePadOut[n]),
            .padOe(linePadOe[n]),
            .pullUpEn(linePullUp[n]),
            .analogSel(lineAnalog[n]),
            .irqEn(lineIrqEn[n]),
            .irqLevel(lineIrqLevel[n])
        );
    end

    // ==========================================================
    // Level read view: pin on inputs, latch on outputs
    always_comb begin
        for (int i = 0; i < io_port_pkg::LINES; i++) begin
            if (dirReg[i] == io_port_pkg::DIR_INPUT) begin
                levelRead[i] = state_q.pinSample[i];
            end else begin
                levelRead[i] = levelLatch[i];
            end
        end
    end

    // ==========================================================
    // Next state: pin sampling, read data, analog selector
    always_comb begin
        int count;
        count = 0;
        state_d = state_q;
        state_d.pinSample = padIn;
        state_d.rdValid = dataRdEn;
        // Read data mux, unmapped reads give zero
        if (dataRdEn) begin
            if (hitLevel) begin
                state_d.rdData = levelRead;
            end else if (hitDir) begin
                state_d.rdData = dirReg;
            end else if (hitOpt) begin
                state_d.rdData = optReg;
            end else begin
                state_d.rdData = io_port_pkg::READ_UNMAPPED;
            end
        end
        // Lowest selected analog line becomes the converter channel
        state_d.analogIndex = io_port_pkg::LINE_IDX_NONE;
        for (int i = io_port_pkg::LINES - 1; i >= 0; i--) begin
            if (lineAnalog[i]) begin
                state_d.analogIndex = io_port_pkg::line_idx_t'(i);
                count = count + 1;
            end
        end
        state_d.analogValid = (count != 0);
        state_d.analogConflict = (count > 1);
    end

    // State register
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q <= '{
                pinSample: io_port_pkg::REG_RESET,
                rdData: io_port_pkg::REG_RESET,
                rdValid: 1'b0,
                analogIndex: io_port_pkg::LINE_IDX_NONE,
                analogValid: 1'b0,
                analogConflict: 1'b0
            };
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // Outputs
    assign dataRdData = state_q.rdData;
    assign dataRdValid = state_q.rdValid;
    assign padOut = linePadOut;
    assign padOe = linePadOe;
    assign pullUpEn = linePullUp;
    assign irqLineEn = lineIrqEn;
    assign irqLineLevel = lineIrqLevel;
    assign analogSel = lineAnalog;
    assign analogIndex = state_q.analogIndex;
    assign analogValid = state_q.analogValid;
    assign analogConflict = state_q.analogConflict;
    assign lineIsOutput = dirReg;

endmodule

`default_nettype wire

// File: shared/io_port_pkg.sv
// Shared constants, address map and mode encoding of the bytewise I/O port
package io_port_pkg;

    // ==========================================================
    // Geometry
    localparam int LINES = 8;
    localparam int LINE_IDX_W = 3;
    typedef logic [LINES-1:0] byte_t;
    typedef logic [LINE_IDX_W-1:0] line_idx_t;

    // ==========================================================
    // Data-space addresses of the three port registers
    localparam logic [7:0] ADDR_LEVEL = 8'hC0;
    localparam logic [7:0] ADDR_DIR = 8'hC4;
    localparam logic [7:0] ADDR_OPT = 8'hCC;

    // ==========================================================
    // Reset and fixed values
    localparam byte_t REG_RESET = 8'h00;
    localparam byte_t READ_UNMAPPED = 8'h00;
    localparam byte_t ANALOG_CAPABLE_ALL = 8'hFF;
    localparam line_idx_t LINE_IDX_NONE = 3'h0;

    // Direction and option bit meanings
    localparam logic DIR_INPUT = 1'b0;
    localparam logic DIR_OUTPUT = 1'b1;
    localparam logic OPT_PLAIN = 1'b0;
    localparam logic OPT_ALT = 1'b1;
    localparam logic LATCH_LOW = 1'b0;
    localparam logic LATCH_HIGH = 1'b1;

    // ==========================================================
    // Per-line operating mode
    typedef enum logic [2:0] {
        MODE_IN_PULLUP,
        MODE_IN_FLOAT,
        MODE_IN_IRQ,
        MODE_ANALOG,
        MODE_OPEN_DRAIN,
        MODE_PUSH_PULL
    } line_mode_e;

endpackage

// File: hw/io_reg_byte.sv
// One 8-bit port register, cleared by reset and loaded on a write strobe
`timescale 1ns/100ps
`default_nettype none

module io_reg_byte (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic wrEn,
    input wire io_port_pkg::byte_t wrData,
    output io_port_pkg::byte_t value
);

    typedef struct packed {
        io_port_pkg::byte_t value;
    } state_s;

    state_s state_q;
    state_s state_d;

    // Next value: write wins, otherwise hold
    always_comb begin
        state_d = state_q;
        if (wrEn) begin
            state_d.value = wrData;
        end
    end

    // State register, cleared on reset
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q <= '{value: io_port_pkg::REG_RESET};
        end else begin
            state_q <= state_d;
        end
    end

    assign value = state_q.value;

endmodule

`default_nettype wire

// File: hw/port_line.sv
// Mode decode and pad control for a single port line
`timescale 1ns/100ps
`default_nettype none

module port_line (
    input wire logic dirBit,
    input wire logic optBit,
    input wire logic latchBit,
    input wire logic pinLevel,
    input wire logic analogOk,
    output io_port_pkg::line_mode_e mode,
    output logic padOut,
    output logic padOe,
    output logic pullUpEn,
    output logic analogSel,
    output logic irqEn,
    output logic irqLevel
);

    // Mode select from direction, option and latch bits
    always_comb begin
        mode = io_port_pkg::MODE_IN_PULLUP;
        if (dirBit == io_port_pkg::DIR_OUTPUT) begin
            if (optBit == io_port_pkg::OPT_PLAIN) begin
                mode = io_port_pkg::MODE_OPEN_DRAIN;
            end else begin
                mode = io_port_pkg::MODE_PUSH_PULL;
            end
        end else if (optBit == io_port_pkg::OPT_PLAIN) begin
            if (latchBit == io_port_pkg::LATCH_HIGH) begin
                mode = io_port_pkg::MODE_IN_FLOAT;
            end else begin
                mode = io_port_pkg::MODE_IN_PULLUP;
            end
        end else if (latchBit == io_port_pkg::LATCH_LOW) begin
            mode = io_port_pkg::MODE_IN_IRQ;
        end else if (analogOk) begin
            mode = io_port_pkg::MODE_ANALOG;
        end else begin
            mode = io_port_pkg::MODE_IN_FLOAT; // No analog path, plain float
        end
    end

    // Pad drivers per mode
    always_comb begin
        padOut = 1'b0;
        padOe = 1'b0;
        pullUpEn = 1'b0;
        analogSel = 1'b0;
        irqEn = 1'b0;
        case (mode)
            io_port_pkg::MODE_IN_PULLUP: begin
                pullUpEn = 1'b1;
            end
            io_port_pkg::MODE_IN_IRQ: begin
                pullUpEn = 1'b1;
                irqEn = 1'b1;
            end
            io_port_pkg::MODE_ANALOG: begin
                analogSel = 1'b1;
            end
            io_port_pkg::MODE_OPEN_DRAIN: begin
                padOut = 1'b0;
                padOe = (latchBit == io_port_pkg::LATCH_LOW);
            end
            io_port_pkg::MODE_PUSH_PULL: begin
                padOut = latchBit;
                padOe = 1'b1;
            end
            default: begin
                padOe = 1'b0;
            end
        endcase
    end

    // Level handed to the interrupt unit, which picks the trigger
    assign irqLevel = irqEn & pinLevel;

endmodule

`default_nettype wire

// File: bench/pin_model.sv
// External pin model for the pad side of the port
`timescale 1ns/100ps
`default_nettype none

module pin_model (
    input wire logic clock,
    input wire io_port_pkg::byte_t padOut,
    input wire io_port_pkg::byte_t padOe,
    input wire io_port_pkg::byte_t pullUpEn,
    input wire io_port_pkg::byte_t extDrive,
    input wire io_port_pkg::byte_t extVal,
    output io_port_pkg::byte_t padIn
);
    io_port_pkg::byte_t floatQ = 8'h5A;

    // Undriven pins wander so a stale level never reads back
    always @(posedge clock) begin
        floatQ <= ~floatQ;
    end

    // Device drive wins, then outside drive, then the pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (padOe[i]) padIn[i] = padOut[i];
            else if (extDrive[i]) padIn[i] = extVal[i];
            else if (pullUpEn[i]) padIn[i] = 1'b1;
            else padIn[i] = floatQ[i];
        end
    end
endmodule

`default_nettype wire

// File: bench/bytewise_io_port_chk.sv
// Concurrent checks on the ports of the I/O port
`timescale 1ns/100ps
`default_nettype none

module bytewise_io_port_chk #(
    parameter logic [7:0] DIR_ADDR = io_port_pkg::ADDR_DIR
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [7:0] dataAddr,
    input wire logic dataWrEn,
    input wire logic dataRdEn,
    input wire logic [7:0] dataWrData,
    input wire logic [7:0] dataRdData,
    input wire logic dataRdValid,
    input wire logic dataHit,
    input wire logic [7:0] padIn,
    input wire logic [7:0] padOut,
    input wire logic [7:0] padOe,
    input wire logic [7:0] pullUpEn,
    input wire logic [7:0] irqLineEn,
    input wire logic [7:0] irqLineLevel,
    input wire logic [7:0] analogSel,
    input wire logic analogValid,
    input wire logic analogConflict,
    input wire logic [7:0] lineIsOutput
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    // ==========================================================
    // Register bus
    a_read_answer: assert property (dataRdEn |=> dataRdValid)
        else $error("read not answered next cycle");
    a_read_quiet: assert property (!dataRdEn |=> !dataRdValid)
        else $error("read valid without a read");
    a_unmapped_zero: assert property (dataRdEn && !dataHit |=> dataRdData == 8'h00)
        else $error("unmapped read not zero");
    a_dir_write: assert property (dataWrEn && dataAddr == DIR_ADDR
        |=> lineIsOutput == $past(dataWrData))
        else $error("direction write lost");
    a_reset_clear: assert property (disable iff (1'b0) sys_rst |=> lineIsOutput == 8'h00
        && padOe == 8'h00 && pullUpEn == 8'hFF && analogSel == 8'h00)
        else $error("reset state wrong");

    // ==========================================================
    // Pads and line modes
    a_input_quiet: assert property ((padOe & ~lineIsOutput) == 8'h00)
        else $error("input line drives pad");
    a_pad_drive: assert property ((padOut & ~padOe) == 8'h00
        && (pullUpEn & lineIsOutput) == 8'h00)
        else $error("pad drive inconsistent");
    a_mode_excl: assert property ((irqLineEn & ~pullUpEn) == 8'h00
        && (analogSel & (pullUpEn | irqLineEn | lineIsOutput)) == 8'h00)
        else $error("mode outputs overlap");
    a_irq_level: assert property (irqLineLevel == (irqLineEn & $past(padIn)))
        else $error("interrupt level wrong");
    a_analog_flags: assert property (analogValid == ($past(analogSel) != 8'h00)
        && analogConflict == (($past(analogSel) & ($past(analogSel) - 8'h01)) != 8'h00))
        else $error("analog flags wrong");

    c_unmapped: cover property (dataRdEn && !dataHit);
    c_conflict: cover property (analogConflict);
    c_push_high: cover property ((padOe & padOut) != 8'h00);
endmodule

bind bytewise_io_port bytewise_io_port_chk #(.DIR_ADDR(DIR_ADDR)) chk_u (.clock, .sys_rst,
    .dataAddr, .dataWrEn, .dataRdEn, .dataWrData, .dataRdData, .dataRdValid, .dataHit,
    .padIn, .padOut, .padOe, .pullUpEn, .irqLineEn, .irqLineLevel, .analogSel,
    .analogValid, .analogConflict, .lineIsOutput);

`default_nettype wire

// File: bench/test_bytewise_io_port.sv
// Self-checking testbench of the bytewise I/O port
`timescale 1ns/100ps
`default_nettype none

module test_bytewise_io_port;
    localparam logic [7:0] LV = io_port_pkg::ADDR_LEVEL;
    localparam logic [7:0] DR = io_port_pkg::ADDR_DIR;
    localparam logic [7:0] OP = io_port_pkg::ADDR_OPT;
    localparam logic [7:0] LINE_MASK = 8'hFF; // All eight lines implemented
    logic clock, sys_rst, dataWrEn, dataRdEn, dataRdValid, dataHit, analogValid, analogConflict;
    logic [7:0] dataAddr, dataWrData, dataRdData, padIn, padOut, padOe, pullUpEn, irqLineEn;
    logic [7:0] irqLineLevel, analogSel, lineIsOutput, extDrive, extVal, d, o, l;
    logic [2:0] analogIndex;
    logic [7:0] expQ[$];
    int err_total = 0;
    int n_tests = 0;
    logic [31:0] seed = 32'h74dc_26df;

    bytewise_io_port dut_u (.clock, .sys_rst, .dataAddr, .dataWrEn, .dataRdEn, .dataWrData,
        .dataRdData, .dataRdValid, .dataHit, .padIn, .padOut, .padOe, .pullUpEn, .irqLineEn,
        .irqLineLevel, .analogSel, .analogIndex, .analogValid, .analogConflict, .lineIsOutput);
    pin_model pins_u (.clock, .padOut, .padOe, .pullUpEn, .extDrive, .extVal, .padIn);

    // ==========================================================
    // Clock, helpers
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task check(input logic [39:0] seen, input logic [39:0] want);
        n_tests++;
        if (seen !== want) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clock);
        dataAddr = a;
        dataWrData = v;
        dataWrEn = 1'b1;
        @(negedge clock);
        dataWrEn = 1'b0;
    endtask

    task rd(input logic [7:0] a, input logic [7:0] want);
        @(negedge clock);
        dataAddr = a;
        dataRdEn = 1'b1;
        expQ.push_back(want);
        @(negedge clock);
        check(dataHit, (a == LV) || (a == DR) || (a == OP));
        dataRdEn = 1'b0;
    endtask

    // Whole-register writes only, never bit operations
    task mode(input logic [7:0] dv, input logic [7:0] ov, input logic [7:0] lv);
        wr(DR, dv);
        wr(OP, ov);
        wr(LV, lv);
        repeat (2) @(negedge clock);
    endtask

    task results;
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Read results come back in order of the queued notes
    always @(negedge clock) begin
        if (dataRdValid === 1'b1) begin
            if (expQ.size() == 0) check(40'h1, 40'h0);
            else check(dataRdData & LINE_MASK, expQ.pop_front() & LINE_MASK);
        end
    end

    // Hang guard
    initial begin
        repeat (50000) @(posedge clock);
        err_total++;
        results();
    end

    // ==========================================================
    // Main sequence
    initial begin
        sys_rst = 1'b1;
        {dataAddr, dataWrEn, dataRdEn, dataWrData, extDrive, extVal} = '0;
        repeat (20) @(posedge clock);
        @(negedge clock) sys_rst = 1'b0;
        check({padOe, padOut, pullUpEn, irqLineEn, analogSel}, 40'h0000_FF00_00);
        rd(DR, 8'h00);
        rd(OP, 8'h00);
        rd(LV, 8'hFF);
        wr(8'h10, 8'hFF);
        rd(8'h10, 8'h00);
        rd(DR, 8'h00);
        // Every mode code applied to all lines
        for (int c = 0; c < 8; c++) begin
            d = {8{c[2]}};
            o = {8{c[1]}};
            l = {8{c[0]}};
            seed = lfsr(seed);
            extVal = seed[7:0];
            extDrive = ~d;
            mode(d, o, l);
            check({padOe, padOut, pullUpEn, irqLineEn, analogSel},
                {d & (o | ~l), d & o & l, ~d & ~l, ~d & o & ~l, ~d & o & l});
            check(irqLineLevel, ~d & o & ~l & extVal);
            rd(LV, (d & l) | (~d & extVal));
        end
        // Mixed lines: open drain outputs beside inputs
        repeat (4) begin
            seed = lfsr(seed);
            {extVal, l, d} = seed[23:0];
            extDrive = ~d;
            mode(d, 8'h00, l);
            check(padOe, d & ~l);
            rd(LV, (d & l) | (~d & extVal));
            wr(OP, 8'hFF);
            wr(DR, 8'hFF);
            check({padOe, padOut}, {8'hFF, l});
            rd(LV, l);
        end
        mode(8'h00, 8'hFF, 8'h20);
        check({analogSel, analogIndex, analogValid, analogConflict}, {8'h20, 3'h5, 2'b10});
        wr(LV, 8'h06);
        repeat (2) @(negedge clock);
        check({analogSel, analogIndex, analogValid, analogConflict}, {8'h06, 3'h1, 2'b11});
        // Write and read of one register in the same cycle
        @(negedge clock);
        dataAddr = DR;
        dataWrData = 8'hA5;
        {dataWrEn, dataRdEn} = 2'b11;
        expQ.push_back(8'h00);
        @(negedge clock);
        {dataWrEn, dataRdEn} = 2'b00;
        rd(DR, 8'hA5);
        // Reset in mid-run
        sys_rst = 1'b1;
        repeat (3) @(negedge clock);
        sys_rst = 1'b0;
        rd(DR, 8'h00);
        rd(OP, 8'h00);
        for (int i = 0; i < 20 && expQ.size() > 0; i++) @(negedge clock);
        if (expQ.size() > 0) err_total++;
        results();
    end
endmodule

`default_nettype wire
